// File: atif_defs.vh
// register map, field positions and reset values of the timer interrupt flag block
// included by every design file of the block except the synchroniser; definitions only
`ifndef ATIF_DEFS_VH
`define ATIF_DEFS_VH

// bus widths
`define ATIF_ADDR_W        8
`define ATIF_DATA_W        16

// register offsets
`define ATIF_OFF_CTRL      8'h00
`define ATIF_OFF_IRQ_EN    8'h0C
`define ATIF_OFF_STATUS    8'h10

// reset values
`define ATIF_CTRL_RESET    16'h0000
`define ATIF_IRQ_EN_RESET  16'h0000
`define ATIF_STATUS_RESET  16'h0000
`define ATIF_RDATA_RESET   16'h0000

// writable and readable bits of each register, everything else reads zero
`define ATIF_CTRL_MASK     16'h007F
`define ATIF_IRQ_EN_MASK   16'h7FFF
`define ATIF_STATUS_MASK   16'h1EFF

// status and enable bit positions (shared layout for bits 7..0)
`define ATIF_BIT_OVF       0
`define ATIF_BIT_CH_LO     1
`define ATIF_BIT_COMM      5
`define ATIF_BIT_TRIG      6
`define ATIF_BIT_BRK       7
`define ATIF_BIT_RECAP_LO  9
`define ATIF_IRQ_SRC_W     8

// dma request enable field of the enable register
`define ATIF_DMA_LO        8
`define ATIF_DMA_W         7

// control register fields
`define ATIF_CTRL_SUSPEND  0
`define ATIF_CTRL_TRG_FALL 1
`define ATIF_CTRL_BRK_LOW  2
`define ATIF_CTRL_CH_IN_LO 3

// channel count
`define ATIF_NUM_CH        4

// timing counts
`define ATIF_TRIG_ARM_CNT  2'h3

`endif

// File: atif_sync.v
// two flip-flop synchroniser for levels that arrive from pins
// assumes the inputs are asynchronous to ref_clk_in and change slowly
`timescale 1ns/100ps
module atif_sync #(
  parameter WIDTH = 1
) (
  // clock and reset
  input  wire             ref_clk_in,
  input  wire             rst_b_in,
  // levels
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] sync_reg;

  // the first stage is read by the second stage only
  always @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      meta_reg <= {WIDTH{1'b0}};
      sync_reg <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;

endmodule

// File: atif_trig_edge.v
// edge detector for the synchronised trigger input
// assumes level_in already passed the synchroniser; evt_out is a one-cycle pulse
`timescale 1ns/100ps
`include "atif_defs.vh"
module atif_trig_edge (
  // clock and reset
  input  wire ref_clk_in,
  input  wire rst_b_in,
  // configuration
  input  wire fall_sel_in,
  input  wire any_edge_in,
  // level and event
  input  wire level_in,
  output wire evt_out
);

  reg       prev_reg;
  reg [1:0] arm_cnt_reg;
  reg       evt_reg;
  reg       edge_hit;
  wire      armed;

  assign armed = (arm_cnt_reg == `ATIF_TRIG_ARM_CNT);

  always @* begin
    if (any_edge_in) begin
      edge_hit = prev_reg ^ level_in;
    end else if (fall_sel_in) begin
      edge_hit = prev_reg & ~level_in;
    end else begin
      edge_hit = ~prev_reg & level_in;
    end
  end

  // the synchroniser restarts from zero, so a pin already high at release
  // would look like a rising edge; edges count only once prev_reg holds a
  // real pin sample
  always @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      prev_reg    <= 1'b0;
      arm_cnt_reg <= 2'h0;
      evt_reg     <= 1'b0;
    end else begin
      prev_reg <= level_in;
      if (!armed) begin
        arm_cnt_reg <= arm_cnt_reg + 2'h1;
      end
      evt_reg  <= armed & edge_hit;
    end
  end

  assign evt_out = evt_reg;

endmodule

// File: atif_irq_core.v
// interrupt enable and interrupt flag logic of an advanced motor timer
// assumes counter, channels and preload logic run on ref_clk_in and hand over
// one-cycle event strobes; trigger and break arrive from pins asynchronously
//
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`timescale 1ns/100ps
`include "atif_defs.vh"

// Overview of operation
// - Trigger, commutation, channel 1 to 4 and overflow each have an enable bit, 1 on, reset 0.
// - Overflow, channel 1 and channel 2 enables sit at bits 0, 1 and 2 of the enable register.
// - Status bits 15 to 13 and 8 read as zero and software leaves them at zero.
// - Channel 1 recapture flag at bit 9 sets on a capture while its flag is set, write zero clears.
// - Channel 2 to 4 recapture flags at bits 10 to 12 behave the same for their channels.
// - Break flag at bit 7 sets while the break input is active and clears on a write of zero.
// - Trigger flag at bit 6 sets on each trigger event and clears on a write of zero.
// - A trigger event is the active edge of the trigger input, or any edge in suspend mode.
// - Commutation flag at bit 5 sets on a commutation event and clears on a write of zero.
// - The commutation event is the moment the channel enables and output controls reload.
// - Channel flags 1 to 4 sit at bits 1 to 4 and all clear on a write of zero.
// - An input channel flag sets on capture and clears on write zero or a data register read.
// - An output channel flag sets on compare and only a software clear removes it.
// - Overflow flag at bit 0 sets on every overflow, software or trigger reinit included.
module atif_irq_core #(
  parameter NUM_CH = `ATIF_NUM_CH
) (
  // clock and reset
  input  wire                       ref_clk_in,
  input  wire                       rst_b_in,
  // register port
  input  wire [`ATIF_ADDR_W-1:0]    addr_in,
  input  wire [`ATIF_DATA_W-1:0]    wdata_in,
  input  wire                       wr_in,
  input  wire                       rd_in,
  output wire [`ATIF_DATA_W-1:0]    rdata_out,
  // pins
  input  wire                       trigger_input_in,
  input  wire                       break_in,
  // event strobes from the timer core
  input  wire                       overflow_evt_in,
  input  wire                       reinit_evt_in,
  input  wire [NUM_CH-1:0]          capture_evt_in,
  input  wire [NUM_CH-1:0]          compare_evt_in,
  input  wire                       preload_update_in,
  input  wire [NUM_CH-1:0]          ch_data_read_in,
  // requests
  output wire                       irq_out,
  output wire [`ATIF_DMA_W-1:0]     dma_req_en_out
);

  // address match, shared by the read and the write decode
  function atif_sel;
    input [`ATIF_ADDR_W-1:0] addr;
    input [`ATIF_ADDR_W-1:0] off;
    begin
      atif_sel = (addr == off);
    end
  endfunction

  // registers
  reg  [`ATIF_DATA_W-1:0] ctrl_reg;
  reg  [`ATIF_DATA_W-1:0] ctrl_next;
  reg  [`ATIF_DATA_W-1:0] irq_dma_enable_reg;
  reg  [`ATIF_DATA_W-1:0] irq_dma_enable_next;
  reg  [`ATIF_DATA_W-1:0] irq_status_flags_reg;
  reg  [`ATIF_DATA_W-1:0] irq_status_flags_next;
  reg  [`ATIF_DATA_W-1:0] rdata_reg;
  reg  [`ATIF_DATA_W-1:0] rdata_next;
  reg                     irq_reg;
  reg                     irq_next;
  reg  [`ATIF_DMA_W-1:0]  dma_en_reg;

  // decoded accesses
  wire                    wr_ctrl;
  wire                    wr_en;
  wire                    wr_status;
  wire                    rd_ctrl;
  wire                    rd_en;
  wire                    rd_status;

  // control fields
  wire                    suspend_mode;
  wire                    trig_fall;
  wire                    brk_active_low;
  wire [NUM_CH-1:0]       ch_input_mode;

  // synchronised pins and derived events
  wire [1:0]              pin_sync;
  wire                    trigger_sync;
  wire                    break_sync;
  wire                    break_active;
  wire                    trigger_evt;

  // per-channel terms
  wire [NUM_CH-1:0]       ch_set;
  wire [NUM_CH-1:0]       ch_rd_clr;
  wire [NUM_CH-1:0]       recap_set;

  // flag update vectors
  reg  [`ATIF_DATA_W-1:0] set_vec;
  reg  [`ATIF_DATA_W-1:0] clr_vec;

  assign wr_ctrl   = wr_in & atif_sel(addr_in, `ATIF_OFF_CTRL);
  assign wr_en     = wr_in & atif_sel(addr_in, `ATIF_OFF_IRQ_EN);
  assign wr_status = wr_in & atif_sel(addr_in, `ATIF_OFF_STATUS);
  assign rd_ctrl   = rd_in & atif_sel(addr_in, `ATIF_OFF_CTRL);
  assign rd_en     = rd_in & atif_sel(addr_in, `ATIF_OFF_IRQ_EN);
  assign rd_status = rd_in & atif_sel(addr_in, `ATIF_OFF_STATUS);

  assign suspend_mode   = ctrl_reg[`ATIF_CTRL_SUSPEND];
  assign trig_fall      = ctrl_reg[`ATIF_CTRL_TRG_FALL];
  assign brk_active_low = ctrl_reg[`ATIF_CTRL_BRK_LOW];
  assign ch_input_mode  = ctrl_reg[`ATIF_CTRL_CH_IN_LO +: NUM_CH];

  // pin synchronisation
  atif_sync #(
    .WIDTH (2)
  ) u_pin_sync (
    .ref_clk_in (ref_clk_in),
    .rst_b_in   (rst_b_in),
    .async_in   ({break_in, trigger_input_in}),
    .sync_out   (pin_sync)
  );

  assign trigger_sync = pin_sync[0];
  assign break_sync   = pin_sync[1];

  // break polarity is programmable; the flag follows the active level
  assign break_active = break_sync ^ brk_active_low;

  // trigger edge detection
  atif_trig_edge u_trig_edge (
    .ref_clk_in  (ref_clk_in),
    .rst_b_in    (rst_b_in),
    .fall_sel_in (trig_fall),
    .any_edge_in (suspend_mode),
    .level_in    (trigger_sync),
    .evt_out     (trigger_evt)
  );

  // channel flag sources, the mode bit picks capture or compare
  genvar c;
  generate
    for (c = 0; c < NUM_CH; c = c + 1) begin : g_ch
      assign ch_set[c]    = ch_input_mode[c] ? capture_evt_in[c] : compare_evt_in[c];
      // reading the captured value acknowledges an input channel only
      assign ch_rd_clr[c] = ch_input_mode[c] & ch_data_read_in[c];
      // recapture looks at the flag as it stands before this cycle's capture
      assign recap_set[c] = ch_input_mode[c] & capture_evt_in[c]
                            & irq_status_flags_reg[`ATIF_BIT_CH_LO + c];
    end
  endgenerate

  // hardware set and software clear terms
  always @* begin
    set_vec = 16'h0000;
    set_vec[`ATIF_BIT_OVF] = overflow_evt_in | reinit_evt_in;
    set_vec[`ATIF_BIT_CH_LO +: NUM_CH] = ch_set;
    set_vec[`ATIF_BIT_COMM] = preload_update_in;
    set_vec[`ATIF_BIT_TRIG] = trigger_evt;
    set_vec[`ATIF_BIT_BRK] = break_active;
    set_vec[`ATIF_BIT_RECAP_LO +: NUM_CH] = recap_set;

    clr_vec = 16'h0000;
    // a zero clears, a one leaves the flag as it is
    if (wr_status) begin
      clr_vec = ~wdata_in & `ATIF_STATUS_MASK;
    end
    clr_vec[`ATIF_BIT_CH_LO +: NUM_CH] = clr_vec[`ATIF_BIT_CH_LO +: NUM_CH] | ch_rd_clr;
  end

  // next-state of the registers
  always @* begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl) begin
      ctrl_next = wdata_in & `ATIF_CTRL_MASK;
    end

    irq_dma_enable_next = irq_dma_enable_reg;
    if (wr_en) begin
      irq_dma_enable_next = wdata_in & `ATIF_IRQ_EN_MASK;
    end

    // set wins over a clear landing in the same cycle, so no event is lost
    irq_status_flags_next = ((irq_status_flags_reg & ~clr_vec) | set_vec)
                            & `ATIF_STATUS_MASK;

    irq_next = |(irq_status_flags_next[`ATIF_IRQ_SRC_W-1:0]
                 & irq_dma_enable_next[`ATIF_IRQ_SRC_W-1:0]);
  end

  // read data stand for exactly one cycle after the read strobe
  always @* begin
    rdata_next = 16'h0000;
    if (rd_ctrl) begin
      rdata_next = ctrl_reg;
    end else if (rd_en) begin
      rdata_next = irq_dma_enable_reg;
    end else if (rd_status) begin
      rdata_next = irq_status_flags_reg & `ATIF_STATUS_MASK;
    end
  end

  always @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      ctrl_reg             <= `ATIF_CTRL_RESET;
      irq_dma_enable_reg   <= `ATIF_IRQ_EN_RESET;
      irq_status_flags_reg <= `ATIF_STATUS_RESET;
      rdata_reg            <= `ATIF_RDATA_RESET;
      irq_reg              <= 1'b0;
      dma_en_reg           <= 7'h00;
    end else begin
      ctrl_reg             <= ctrl_next;
      irq_dma_enable_reg   <= irq_dma_enable_next;
      irq_status_flags_reg <= irq_status_flags_next;
      rdata_reg            <= rdata_next;
      irq_reg              <= irq_next;
      dma_en_reg           <= irq_dma_enable_next[`ATIF_DMA_LO +: `ATIF_DMA_W];
    end
  end

  assign rdata_out      = rdata_reg;
  assign irq_out        = irq_reg;
  assign dma_req_en_out = dma_en_reg;

endmodule

// File: atif_irq_monitor.sv
// assertions on the ports of the timer interrupt flag block
// assumes one clock and the synchronous active-low reset of the block
`timescale 1ns/100ps
`include "atif_defs.vh"
module atif_irq_monitor #(
  parameter NUM_CH = 4
) (
  // clock and reset
  input wire              ref_clk_in,
  input wire              rst_b_in,
  // register port
  input wire [7:0]        addr_in,
  input wire [15:0]       wdata_in,
  input wire              wr_in,
  input wire              rd_in,
  input wire [15:0]       rdata_out,
  // events and request
  input wire              break_in,
  input wire              overflow_evt_in,
  input wire [NUM_CH-1:0] compare_evt_in,
  input wire              preload_update_in,
  input wire [NUM_CH-1:0] ch_data_read_in,
  input wire              irq_out
);
  reg [15:0] en_reg;
  reg [15:0] ctl_reg;
  // shadows of the enable and control registers, so each request can be traced to its cause
  always @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      en_reg  <= 16'h0000;
      ctl_reg <= 16'h0000;
    end else if (wr_in && addr_in == `ATIF_OFF_IRQ_EN) begin
      en_reg  <= wdata_in & `ATIF_IRQ_EN_MASK;
    end else if (wr_in && addr_in == `ATIF_OFF_CTRL) begin
      ctl_reg <= wdata_in & `ATIF_CTRL_MASK;
    end
  end
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);
  chk_rsvd_zero: assert property (
    $past(rd_in) && $past(addr_in) == `ATIF_OFF_STATUS |-> (rdata_out & 16'hE100) == 16'h0000)
    else $error("reserved status bits set");
  chk_en_readback: assert property (
    $past(rd_in) && $past(addr_in) == `ATIF_OFF_IRQ_EN |-> rdata_out == en_reg)
    else $error("enable readback wrong");
  chk_ovf_irq: assert property (
    overflow_evt_in && en_reg[0] && !wr_in |=> irq_out)
    else $error("overflow gave no irq");
  chk_cmp_irq: assert property (
    compare_evt_in[1] && en_reg[2] && !ctl_reg[4] && !wr_in |=> irq_out)
    else $error("compare gave no irq");
  chk_comm_irq: assert property (
    preload_update_in && en_reg[5] && !wr_in |=> irq_out)
    else $error("reload gave no irq");
  chk_brk_irq: assert property (
    break_in [*4] ##0 (en_reg[7] && !ctl_reg[2] && !wr_in) |=> irq_out)
    else $error("break gave no irq");
  chk_mask_off: assert property (
    en_reg[7:0] == 8'h00 && !wr_in |=> !irq_out)
    else $error("irq while all disabled");
  chk_irq_hold: assert property (
    irq_out && !wr_in && !(|ch_data_read_in) |=> irq_out)
    else $error("irq dropped without clear");
endmodule
bind atif_irq_core atif_irq_monitor #(.NUM_CH(NUM_CH)) i_mon (
  .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .break_in(break_in),
  .overflow_evt_in(overflow_evt_in), .compare_evt_in(compare_evt_in),
  .preload_update_in(preload_update_in), .ch_data_read_in(ch_data_read_in), .irq_out(irq_out));

// File: atif_sw_model.sv
// software side of the register port: one-cycle strobes, read data a cycle later
// assumes the block's clock; the bench calls its tasks one after another
`timescale 1ns/100ps
`include "atif_defs.vh"
module atif_sw_model (
  // clock
  input  wire        ref_clk_in,
  // register port
  output reg  [7:0]  addr_out = 8'h00,
  output reg  [15:0] wdata_out = 16'h0000,
  output reg         wr_out = 1'b0,
  output reg         rd_out = 1'b0,
  input  wire [15:0] rdata_in
);
  task wr(input [7:0] a, input [15:0] d);
    begin
      @(posedge ref_clk_in);
      addr_out  <= a;
      wdata_out <= (a == `ATIF_OFF_STATUS) ? (d & `ATIF_STATUS_MASK) : d;
      wr_out    <= 1'b1;
      @(posedge ref_clk_in);
      wr_out <= 1'b0;
      #1;
    end
  endtask
  task rd(input [7:0] a, output [15:0] d);
    begin
      @(posedge ref_clk_in);
      addr_out <= a;
      rd_out   <= 1'b1;
      @(posedge ref_clk_in);
      rd_out <= 1'b0;
      #1;
      d = rdata_in;
    end
  endtask
endmodule

// File: tb_top.sv
// self-checking bench of the timer interrupt flag block
// assumes the software model drives the register port, the bench the event strobes
`timescale 1ns/100ps
`include "atif_defs.vh"
module tb_top;
  reg         ref_clk_in = 1'b0;
  reg         rst_b_in = 1'b0;
  reg         trig = 1'b0, brk = 1'b0, ovf = 1'b0, reinit = 1'b0, pre = 1'b0;
  reg  [3:0]  cap = 4'h0, cmp = 4'h0, dread = 4'h0;
  wire [7:0]  addr;
  wire [15:0] wdata, rdata;
  wire        wr, rd, irq;
  wire [6:0]  dma;
  reg  [15:0] got;
  integer     failures = 0, cmp_count = 0, i, b;
  always #25 ref_clk_in = ~ref_clk_in;
  atif_sw_model i_sw (.ref_clk_in(ref_clk_in), .addr_out(addr), .wdata_out(wdata),
    .wr_out(wr), .rd_out(rd), .rdata_in(rdata));
  atif_irq_core #(.NUM_CH(4)) i_dut (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
    .trigger_input_in(trig), .break_in(brk), .overflow_evt_in(ovf), .reinit_evt_in(reinit),
    .capture_evt_in(cap), .compare_evt_in(cmp), .preload_update_in(pre),
    .ch_data_read_in(dread), .irq_out(irq), .dma_req_en_out(dma));
  task chk(input [15:0] g, input [15:0] e);
    begin
      cmp_count = cmp_count + 1;
      if (g !== e) begin
        failures = failures + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  task rds(input [15:0] e);
    begin
      i_sw.rd(`ATIF_OFF_STATUS, got);
      chk(got, e);
    end
  endtask
  // break is held long enough to pass the synchroniser, then released so it can clear
  task fire(input integer k);
    begin
      @(posedge ref_clk_in);
      case (k)
        0: ovf <= 1'b1;
        5: pre <= 1'b1;
        6: trig <= 1'b1;
        7: brk <= 1'b1;
        8: reinit <= 1'b1;
        default: cmp[k-1] <= 1'b1;
      endcase
      @(posedge ref_clk_in);
      {ovf, pre, reinit, cmp} <= 7'h00;
      // a data read must not clear an output channel flag
      dread <= 4'hF;
      @(posedge ref_clk_in) dread <= 4'h0;
      repeat (4) @(posedge ref_clk_in);
      brk <= 1'b0;
      repeat (5) @(posedge ref_clk_in);
    end
  endtask
  task trg(input v, input [15:0] e);
    begin
      @(posedge ref_clk_in) trig <= v;
      repeat (6) @(posedge ref_clk_in);
      rds(e);
      i_sw.wr(`ATIF_OFF_STATUS, 16'h0000);
    end
  endtask
  task conclude;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  initial begin
    #400000;
    failures = failures + 1;
    conclude;
  end
  initial begin
    repeat (5) @(posedge ref_clk_in);
    rst_b_in <= 1'b1;
    rds(16'h0000);
    i_sw.rd(`ATIF_OFF_IRQ_EN, got);
    chk(got, 16'h0000);
    i_sw.rd(8'h04, got);
    chk(got, 16'h0000);
    i_sw.wr(`ATIF_OFF_IRQ_EN, 16'hFFFF);
    chk({9'h000, dma}, 16'h007F);
    i_sw.rd(`ATIF_OFF_IRQ_EN, got);
    chk(got, 16'h7FFF);
    // each source alone: flag, irq with its enable, masked while pending, then cleared
    for (i = 0; i < 9; i = i + 1) begin
      b = (i == 8) ? 0 : i;
      i_sw.wr(`ATIF_OFF_IRQ_EN, 16'h0001 << b);
      fire(i);
      rds(16'h0001 << b);
      chk({15'h0000, irq}, 16'h0001);
      i_sw.wr(`ATIF_OFF_IRQ_EN, ~(16'h0001 << b) & 16'h00FF);
      chk({15'h0000, irq}, 16'h0000);
      i_sw.wr(`ATIF_OFF_STATUS, ~(16'h0001 << b));
      rds(16'h0000);
    end
    trg(1'b0, 16'h0000);
    i_sw.wr(`ATIF_OFF_CTRL, 16'h0002);
    trg(1'b1, 16'h0000);
    trg(1'b0, 16'h0040);
    i_sw.wr(`ATIF_OFF_CTRL, 16'h0001);
    trg(1'b1, 16'h0040);
    trg(1'b0, 16'h0040);
    i_sw.wr(`ATIF_OFF_CTRL, 16'h0078);
    // compares are ignored while the channels are inputs
    @(posedge ref_clk_in) {cap, cmp} <= 8'hFF;
    @(posedge ref_clk_in) {cap, cmp} <= 8'h00;
    rds(16'h001E);
    @(posedge ref_clk_in) cap <= 4'hF;
    @(posedge ref_clk_in) cap <= 4'h0;
    rds(16'h1E1E);
    @(posedge ref_clk_in) dread <= 4'h1;
    @(posedge ref_clk_in) dread <= 4'h0;
    rds(16'h1E1C);
    i_sw.wr(`ATIF_OFF_STATUS, 16'hFFFF);
    rds(16'h1E1C);
    i_sw.wr(`ATIF_OFF_STATUS, 16'h0000);
    rds(16'h0000);
    // active-low break: a low pin is active, a high pin lets the flag clear
    i_sw.wr(`ATIF_OFF_CTRL, 16'h0004);
    rds(16'h0080);
    @(posedge ref_clk_in) brk <= 1'b1;
    repeat (4) @(posedge ref_clk_in);
    i_sw.wr(`ATIF_OFF_STATUS, 16'h0000);
    rds(16'h0000);
    conclude;
  end
endmodule
